// ---- rtl/dcr_regs.sv ----
// Purpose: configuration register bank of a serial video deserializer
// Assumes: a bus protocol engine on clk delivers byte accesses
// Notes: straps and power-down arrive from pins and are synchronised

// Overview of operation
// (RL1) Register 0 bit 7 picks spread range: 0 high band, 1 low band.
// (RL2) Register 0 bit 1 requests sleep; all register contents are kept.
// (RL3) Register 0 bit 0 picks straps or registers for all but address.
// (RL4) Register 1 bit 7 picks strap decode or register address.
// (RL5) Register 1 bits 6:0 hold address; only 71,72,73,76 hex valid.
// (RL6) Register 2 bit 7 drives or floats the video outputs.
// (RL7) Register 2 bit 3 selects 250 or 400 mV output swing.
// (RL8) High band codes 1-4: 0.9,1.2,1.9,2.3 percent at clock/2168.
// (RL9) High band codes 5-7: 0.7,1.3,1.57 percent at clock/1300.
// (RL10) Low band codes 1-4: 0.7,1.3,1.8,2.2 percent at clock/625.
// (RL11) Low band top codes: 1.2 and 1.7 percent at clock/385.
// (RL12) Register 0 resets to zero; writing 01h hands control to registers.
// (RL13) Power-down pin returns every register to its default.
// (RL14) Loss-of-stream sleep leaves all register contents unchanged.
// (RL15) Byte registers; reserved bits store and read back written value.
module dcr_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register access from the bus engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_index,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Pins
  input wire logic power_down_n,
  input wire logic [1:0] addr_strap,
  input wire dcr_pkg::dcr_cfg_type strap_cfg,
  // Link state from the recovery logic
  input wire logic stream_lost,
  // Effective configuration
  output dcr_pkg::dcr_cfg_type cfg,
  output dcr_pkg::dcr_spread_type spread,
  output logic [6:0] slave_addr_value,
  output logic slave_addr_reserved,
  output logic sleep_req,
  output logic low_power
);

  // ==========================================================
  // Pin synchronisation
  localparam int CFG_W = $bits(dcr_pkg::dcr_cfg_type);
  localparam int PIN_W = CFG_W + 3;

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_sync;
  logic pd_n_s;
  logic [1:0] addr_strap_s;
  dcr_pkg::dcr_cfg_type strap_s;

  assign pins_raw = {power_down_n, addr_strap, strap_cfg};
  assign pd_n_s = pins_sync[PIN_W-1];
  assign addr_strap_s = pins_sync[PIN_W-2:PIN_W-3];
  assign strap_s = pins_sync[CFG_W-1:0];

  // Power-down reads as asserted until the pin is seen high
  dcr_pin_sync #(
    .WIDTH(PIN_W),
    .RESET_VAL('0)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .pin_in(pins_raw),
    .pin_out(pins_sync)
  );

  // ==========================================================
  // Register file
  logic [dcr_pkg::REG_COUNT-1:0][7:0] regs_q, regs_d;
  logic [7:0] rdata_q, rdata_d;
  logic idx_mapped;

  assign idx_mapped = (reg_index[7:2] == 6'h00);

  always_comb begin
    regs_d = regs_q;
    rdata_d = rdata_q;
    if (!pd_n_s) begin
      // Power-down wipes the bank and blocks writes [RL13]
      regs_d[dcr_pkg::REG_CFG_ONE[1:0]] = dcr_pkg::RST_CFG_ONE; // [RL12]
      regs_d[dcr_pkg::REG_SLAVE_ADDR[1:0]] = dcr_pkg::RST_SLAVE_ADDR;
      regs_d[dcr_pkg::REG_OUT_FEAT[1:0]] = dcr_pkg::RST_OUT_FEAT;
      regs_d[dcr_pkg::REG_EQ_SPREAD[1:0]] = dcr_pkg::RST_EQ_SPREAD;
    end else if (reg_wr && idx_mapped) begin
      // Whole byte stored, reserved bits included [RL15]
      regs_d[reg_index[1:0]] = reg_wdata;
    end
    // Stream loss is not looked at here, so contents survive it [RL14]
    if (reg_rd) begin
      rdata_d = idx_mapped ? regs_q[reg_index[1:0]] : 8'h00; // [RL15]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regs_q[dcr_pkg::REG_CFG_ONE[1:0]] <= dcr_pkg::RST_CFG_ONE; // [RL12]
      regs_q[dcr_pkg::REG_SLAVE_ADDR[1:0]] <= dcr_pkg::RST_SLAVE_ADDR;
      regs_q[dcr_pkg::REG_OUT_FEAT[1:0]] <= dcr_pkg::RST_OUT_FEAT;
      regs_q[dcr_pkg::REG_EQ_SPREAD[1:0]] <= dcr_pkg::RST_EQ_SPREAD;
      rdata_q <= 8'h00;
    end else begin
      regs_q <= regs_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ==========================================================
  // Configuration source selection
  logic [7:0] r0, r1, r2, r3;
  dcr_pkg::dcr_cfg_type cfg_reg, cfg_sel;

  assign r0 = regs_q[dcr_pkg::REG_CFG_ONE[1:0]];
  assign r1 = regs_q[dcr_pkg::REG_SLAVE_ADDR[1:0]];
  assign r2 = regs_q[dcr_pkg::REG_OUT_FEAT[1:0]];
  assign r3 = regs_q[dcr_pkg::REG_EQ_SPREAD[1:0]];

  always_comb begin
    cfg_reg.low_freq_range_sel = r0[dcr_pkg::LOW_FREQ_BIT]; // [RL1]
    cfg_reg.output_sleep_state_sel = r0[dcr_pkg::OSS_BIT];
    cfg_reg.output_drive_enable = r2[dcr_pkg::OEN_BIT]; // [RL6]
    cfg_reg.output_swing_sel = r2[dcr_pkg::SWING_BIT]; // [RL7]
    cfg_reg.oscillator_freq_sel = r2[dcr_pkg::OSC_LSB +: 3];
    cfg_reg.rx_equalizer_on = r3[dcr_pkg::EQ_ON_BIT];
    cfg_reg.rx_equalizer_gain = r3[dcr_pkg::RX_EQUALIZER_GAIN_LSB +: 3];
    cfg_reg.spread_profile_sel = r3[dcr_pkg::SPREAD_LSB +: 3];
    // Straps rule until software sets the control bit [RL3] [RL12]
    cfg_sel = r0[dcr_pkg::REG_CTRL_BIT] ? cfg_reg : strap_s;
  end

  // ==========================================================
  // Spread profile decode
  dcr_pkg::dcr_spread_type spread_sel;

  always_comb begin
    spread_sel.spread_on = (cfg_sel.spread_profile_sel != 3'h0);
    spread_sel.dev_hundredths = dcr_pkg::DEV_000;
    spread_sel.mod_divider = dcr_pkg::DIV_NONE;
    if (!cfg_sel.low_freq_range_sel) begin
      case (cfg_sel.spread_profile_sel)
        3'h1: begin
          spread_sel.dev_hundredths = dcr_pkg::DEV_090; // [RL8]
          spread_sel.mod_divider = dcr_pkg::DIV_2168;
        end
        3'h2: begin
          spread_sel.dev_hundredths = dcr_pkg::DEV_120; // [RL8]
          spread_sel.mod_divider = dcr_pkg::DIV_2168;
        end
        3'h3: begin
          spread_sel.dev_hundredths = dcr_pkg::DEV_190; // [RL8]
          spread_sel.mod_divider = dcr_pkg::DIV_2168;
        end
        3'h4: begin
          spread_sel.dev_hundredths = dcr_pkg::DEV_230; // [RL8]
          spread_sel.mod_divider = dcr_pkg::DIV_2168;
        end
        3'h5: begin
          spread_sel.dev_hundredths = dcr_pkg::DEV_070; // [RL9]
          spread_sel.mod_divider = dcr_pkg::DIV_1300;
        end
        3'h6: begin
          spread_sel.dev_hundredths = dcr_pkg::DEV_130; // [RL9]
          spread_sel.mod_divider = dcr_pkg::DIV_1300;
        end
        3'h7: begin
          spread_sel.dev_hundredths = dcr_pkg::DEV_157; // [RL9]
          spread_sel.mod_divider = dcr_pkg::DIV_1300;
        end
        default: begin
          spread_sel.dev_hundredths = dcr_pkg::DEV_000; // [RL8]
          spread_sel.mod_divider = dcr_pkg::DIV_NONE;
        end
      endcase
    end else begin
      case (cfg_sel.spread_profile_sel)
        3'h1: begin
          spread_sel.dev_hundredths = dcr_pkg::DEV_070; // [RL10]
          spread_sel.mod_divider = dcr_pkg::DIV_625;
        end
        3'h2: begin
          spread_sel.dev_hundredths = dcr_pkg::DEV_130; // [RL10]
          spread_sel.mod_divider = dcr_pkg::DIV_625;
        end
        3'h3: begin
          spread_sel.dev_hundredths = dcr_pkg::DEV_180; // [RL10]
          spread_sel.mod_divider = dcr_pkg::DIV_625;
        end
        3'h4: begin
          spread_sel.dev_hundredths = dcr_pkg::DEV_220; // [RL10]
          spread_sel.mod_divider = dcr_pkg::DIV_625;
        end
        3'h5: begin
          // Code 5 of the low band shares the clock/385 rate
          spread_sel.dev_hundredths = dcr_pkg::DEV_070;
          spread_sel.mod_divider = dcr_pkg::DIV_385;
        end
        3'h6: begin
          spread_sel.dev_hundredths = dcr_pkg::DEV_120; // [RL11]
          spread_sel.mod_divider = dcr_pkg::DIV_385;
        end
        3'h7: begin
          spread_sel.dev_hundredths = dcr_pkg::DEV_170; // [RL11]
          spread_sel.mod_divider = dcr_pkg::DIV_385;
        end
        default: begin
          spread_sel.dev_hundredths = dcr_pkg::DEV_000; // [RL10]
          spread_sel.mod_divider = dcr_pkg::DIV_NONE;
        end
      endcase
    end
  end

  // ==========================================================
  // Bus address selection, never taken over by the control bit
  logic [6:0] strap_addr, addr_sel;
  logic addr_bad;

  always_comb begin
    case (addr_strap_s)
      2'h0: strap_addr = dcr_pkg::ADDR_ID0;
      2'h1: strap_addr = dcr_pkg::ADDR_ID1;
      2'h2: strap_addr = dcr_pkg::ADDR_ID2;
      default: strap_addr = dcr_pkg::ADDR_ID3;
    endcase
    addr_sel = r1[dcr_pkg::ADDR_SRC_BIT] ?
      r1[dcr_pkg::ADDR_MSB:0] : strap_addr; // [RL4]
    // Reserved codes are flagged, not blocked, so software can recover
    addr_bad = (addr_sel != dcr_pkg::ADDR_ID0) &&
      (addr_sel != dcr_pkg::ADDR_ID1) &&
      (addr_sel != dcr_pkg::ADDR_ID2) &&
      (addr_sel != dcr_pkg::ADDR_ID3); // [RL5]
  end

  // ==========================================================
  // Registered outputs
  dcr_pkg::dcr_cfg_type cfg_q;
  dcr_pkg::dcr_spread_type spread_q;
  logic [6:0] addr_q;
  logic addr_bad_q, sleep_q, low_power_q;
  logic sleep_d, low_power_d;

  always_comb begin
    sleep_d = r0[dcr_pkg::SLEEP_BIT]; // [RL2]
    // Either sleep keeps the bank as it is [RL2] [RL14]
    low_power_d = sleep_d | stream_lost | ~pd_n_s;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= '0;
      spread_q <= '0;
      addr_q <= dcr_pkg::ADDR_ID0;
      addr_bad_q <= 1'b0;
      sleep_q <= 1'b0;
      low_power_q <= 1'b1;
    end else begin
      cfg_q <= cfg_sel;
      spread_q <= spread_sel;
      addr_q <= addr_sel;
      addr_bad_q <= addr_bad;
      sleep_q <= sleep_d;
      low_power_q <= low_power_d;
    end
  end

  assign cfg = cfg_q;
  assign spread = spread_q;
  assign slave_addr_value = addr_q;
  assign slave_addr_reserved = addr_bad_q;
  assign sleep_req = sleep_q;
  assign low_power = low_power_q;

endmodule

// ---- rtl/dcr_pkg.sv ----
// Purpose: constants and types of the deserializer configuration bank
// Assumes: byte-wide registers, one-byte register index
// Notes: spread deviations are given in hundredths of a percent
package dcr_pkg;

  // ==========================================================
  // Register indices
  localparam logic [7:0] REG_CFG_ONE = 8'h00;
  localparam logic [7:0] REG_SLAVE_ADDR = 8'h01;
  localparam logic [7:0] REG_OUT_FEAT = 8'h02;
  localparam logic [7:0] REG_EQ_SPREAD = 8'h03;
  localparam int REG_COUNT = 4;

  // ==========================================================
  // Field positions
  localparam int LOW_FREQ_BIT = 7;
  localparam int OSS_BIT = 6;
  localparam int SLEEP_BIT = 1;
  localparam int REG_CTRL_BIT = 0;
  localparam int ADDR_SRC_BIT = 7;
  localparam int ADDR_MSB = 6;
  localparam int OEN_BIT = 7;
  localparam int SWING_BIT = 3;
  localparam int OSC_LSB = 0;
  localparam int RX_EQUALIZER_GAIN_LSB = 5;
  localparam int EQ_ON_BIT = 4;
  localparam int SPREAD_LSB = 0;

  // ==========================================================
  // Values after reset, and the register 0 value that hands control to registers
  localparam logic [7:0] RST_CFG_ONE = 8'h00;
  localparam logic [7:0] RST_SLAVE_ADDR = 8'h70;
  localparam logic [7:0] RST_OUT_FEAT = 8'h00;
  localparam logic [7:0] RST_EQ_SPREAD = 8'h00;
  localparam logic [7:0] REG_CTRL_ENABLE = 8'h01;

  // ==========================================================
  // Valid bus addresses, in strap decode order
  localparam logic [6:0] ADDR_ID0 = 7'h71;
  localparam logic [6:0] ADDR_ID1 = 7'h72;
  localparam logic [6:0] ADDR_ID2 = 7'h73;
  localparam logic [6:0] ADDR_ID3 = 7'h76;

  // ==========================================================
  // Spread modulation dividers and deviations
  localparam logic [11:0] DIV_NONE = 12'h000;
  localparam logic [11:0] DIV_2168 = 12'h878;
  localparam logic [11:0] DIV_1300 = 12'h514;
  localparam logic [11:0] DIV_625 = 12'h271;
  localparam logic [11:0] DIV_385 = 12'h181;
  localparam logic [7:0] DEV_000 = 8'h00;
  localparam logic [7:0] DEV_070 = 8'h46;
  localparam logic [7:0] DEV_090 = 8'h5A;
  localparam logic [7:0] DEV_120 = 8'h78;
  localparam logic [7:0] DEV_130 = 8'h82;
  localparam logic [7:0] DEV_157 = 8'h9D;
  localparam logic [7:0] DEV_170 = 8'hAA;
  localparam logic [7:0] DEV_180 = 8'hB4;
  localparam logic [7:0] DEV_190 = 8'hBE;
  localparam logic [7:0] DEV_220 = 8'hDC;
  localparam logic [7:0] DEV_230 = 8'hE6;

  // ==========================================================
  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;

  // ==========================================================
  // Configuration carried from straps or registers
  typedef struct packed {
    logic low_freq_range_sel;
    logic output_sleep_state_sel;
    logic output_drive_enable;
    logic output_swing_sel;
    logic [2:0] oscillator_freq_sel;
    logic rx_equalizer_on;
    logic [2:0] rx_equalizer_gain;
    logic [2:0] spread_profile_sel;
  } dcr_cfg_type;

  typedef struct packed {
    logic spread_on;
    logic [7:0] dev_hundredths;
    logic [11:0] mod_divider;
  } dcr_spread_type;

endpackage

// ---- rtl/dcr_pin_sync.sv ----
// Purpose: three-stage synchroniser with agreement filter for pins
// Assumes: inputs are asynchronous to clk
// Notes: a change is taken once stages two and three agree
module dcr_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins and filtered result
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  // ==========================================================
  // Per-bit chain
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic s1_q, s2_q, s3_q, out_q;
      logic out_d;
      always_comb begin
        // First stage feeds only the second stage
        out_d = (s2_q == s3_q) ? s3_q : out_q;
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_q <= RESET_VAL[gi];
          s2_q <= RESET_VAL[gi];
          s3_q <= RESET_VAL[gi];
          out_q <= RESET_VAL[gi];
        end else begin
          s1_q <= pin_in[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          out_q <= out_d;
        end
      end
      assign pin_out[gi] = out_q;
    end
  endgenerate

endmodule

// ---- tb/dcr_regs_checker.sv ----
// Purpose: concurrent checks on the configuration bank ports
// Assumes: register and config outputs are registered, one clock
// Notes: attached to the top module by bind
module dcr_regs_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Observed ports
  input wire logic reg_rd,
  input wire logic [7:0] reg_index,
  input wire logic [7:0] reg_rdata,
  input wire logic power_down_n,
  input wire logic stream_lost,
  input wire dcr_pkg::dcr_cfg_type cfg,
  input wire dcr_pkg::dcr_spread_type spread,
  input wire logic [6:0] slave_addr_value,
  input wire logic slave_addr_reserved,
  input wire logic sleep_req,
  input wire logic low_power
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rdata_hold: assert property (!$past(reg_rd) |->
    $stable(reg_rdata)) else $error("read data moved without a read");
  a_unmapped_rd: assert property (reg_rd && reg_index > 8'h03 |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_sleep_power: assert property ($rose(sleep_req) |->
    ##[0:1] low_power) else $error("sleep without low power");
  a_stream_power: assert property (stream_lost |=> low_power)
    else $error("stream loss without low power");
  a_spread_off: assert property (cfg.spread_profile_sel == 3'h0 |->
    spread == '0) else $error("spread on for code zero");
  a_high_div_a: assert property (!cfg.low_freq_range_sel &&
    cfg.spread_profile_sel inside {[3'h1:3'h4]} |-> spread.spread_on &&
    spread.mod_divider == dcr_pkg::DIV_2168) else $error("high band div 1-4");
  a_high_div_b: assert property (!cfg.low_freq_range_sel &&
    cfg.spread_profile_sel > 3'h4 |-> spread.spread_on &&
    spread.mod_divider == dcr_pkg::DIV_1300) else $error("high band div 5-7");
  a_low_div_a: assert property (cfg.low_freq_range_sel &&
    cfg.spread_profile_sel inside {[3'h1:3'h4]} |-> spread.spread_on &&
    spread.mod_divider == dcr_pkg::DIV_625) else $error("low band div 1-4");
  a_low_div_b: assert property (cfg.low_freq_range_sel &&
    cfg.spread_profile_sel > 3'h5 |-> spread.spread_on &&
    spread.mod_divider == dcr_pkg::DIV_385) else $error("low band div 6-7");
  a_addr_flag: assert property (slave_addr_reserved ==
    !(slave_addr_value inside {7'h71, 7'h72, 7'h73, 7'h76}))
    else $error("reserved address flag wrong");
  a_pd_defaults: assert property (!power_down_n [*8] |->
    !sleep_req && low_power) else $error("power-down kept settings");
endmodule

bind dcr_regs dcr_regs_checker i_chk (.clk, .rst, .reg_rd, .reg_index,
  .reg_rdata, .power_down_n, .stream_lost, .cfg, .spread,
  .slave_addr_value, .slave_addr_reserved, .sleep_req, .low_power);

// ---- tb/dcr_host_model.sv ----
// Purpose: bus engine side model issuing single byte accesses
// Assumes: strobes sampled at the next rising edge
// Notes: write data is scrambled once released
module dcr_host_model (
  // Clock
  input wire logic clk,
  // Register access
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_index,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_index = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_index <= idx;
    reg_wdata <= data;
    @(posedge clk);
    reg_wr <= 1'h0;
    reg_wdata <= ~data;
  endtask
  // Data is valid just after the taking edge, so no extra cycle
  task automatic rd(input logic [7:0] idx, output logic [7:0] data);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_index <= idx;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    data = reg_rdata;
  endtask
endmodule

// ---- tb/test_dcr_regs.sv ----
// Purpose: self-checking bench of the configuration bank
// Assumes: power-down pin high before reset release
// Notes: waits are fixed counts from the synchroniser depth
module test_dcr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, reg_wr, reg_rd, power_down_n, stream_lost;
  logic [7:0] reg_index, reg_wdata, reg_rdata, rv;
  logic [1:0] addr_strap;
  logic [6:0] slave_addr_value;
  logic slave_addr_reserved, sleep_req, low_power;
  dcr_pkg::dcr_cfg_type strap_cfg, cfg;
  dcr_pkg::dcr_spread_type spread;
  int failures, n_tests;
  logic [7:0] dflt [4] = '{8'h00, 8'h70, 8'h00, 8'h00};
  logic [7:0] pat [4] = '{8'h3D, 8'hF5, 8'h7B, 8'hFF};
  logic [7:0] dev_t [16] = '{8'h00, 8'h5A, 8'h78, 8'hBE, 8'hE6, 8'h46,
    8'h82, 8'h9D, 8'h00, 8'h46, 8'h82, 8'hB4, 8'hDC, 8'h46, 8'h78, 8'hAA};

  dcr_host_model i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  dcr_regs i_dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .power_down_n(power_down_n), .addr_strap(addr_strap),
    .strap_cfg(strap_cfg), .stream_lost(stream_lost), .cfg(cfg),
    .spread(spread), .slave_addr_value(slave_addr_value),
    .slave_addr_reserved(slave_addr_reserved), .sleep_req(sleep_req),
    .low_power(low_power));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check_dflt();
    for (int i = 0; i < 4; i++) begin
      i_host.rd(8'(i), rv);
      check("default", rv, dflt[i]);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check_dflt();
    check("strap addr", slave_addr_value, 7'h71);
  endtask
  task automatic t_straps();
    @(posedge clk);
    strap_cfg <= 14'h1555;
    addr_strap <= 2'h3;
    settle(6);
    check("pin cfg", cfg, 14'h1555);
    check("strap addr", slave_addr_value, 7'h76);
  endtask
  task automatic t_regs();
    i_host.wr(8'h00, 8'h01);
    i_host.wr(8'h02, 8'h8D);
    i_host.wr(8'h03, 8'hB6);
    settle(3);
    check("reg cfg", cfg, {4'h3, 3'h5, 1'h1, 3'h5, 3'h6});
    check("swing", cfg.output_swing_sel, 1'h1);
    check("oen on", cfg.output_drive_enable, 1'h1);
    i_host.wr(8'h02, 8'h00);
    settle(3);
    check("oen off", cfg.output_drive_enable, 1'h0);
    check("swing off", cfg.output_swing_sel, 1'h0);
  endtask
  task automatic t_readback();
    for (int i = 0; i < 4; i++) i_host.wr(8'(i), pat[i]);
    i_host.wr(8'h04, 8'hAA);
    for (int i = 0; i < 5; i++) begin
      i_host.rd(8'(i), rv);
      check("readback", rv, (i < 4) ? pat[i] : 8'h00);
    end
    settle(2);
    check("reg addr", slave_addr_value, 7'h75);
    check("rsv flag", slave_addr_reserved, 1'h1);
    i_host.wr(8'h01, 8'hF6);
    settle(3);
    check("valid flag", slave_addr_reserved, 1'h0);
    check("valid addr", slave_addr_value, 7'h76);
  endtask
  task automatic t_spread();
    logic [11:0] dv;
    logic [20:0] exp_s;
    for (int k = 0; k < 16; k++) begin
      i_host.wr(8'h00, {k[3], 7'h01});
      i_host.wr(8'h03, {5'h00, k[2:0]});
      settle(3);
      dv = (k[2:0] == 3'h0) ? 12'h000 : k[3] ?
        ((k[2:0] < 3'h5) ? 12'h271 : 12'h181) :
        ((k[2:0] < 3'h5) ? 12'h878 : 12'h514);
      exp_s = {k[2:0] != 3'h0, dev_t[k], dv};
      check("band", cfg.low_freq_range_sel, k[3]);
      check("spread", spread, exp_s);
    end
  endtask
  task automatic t_sleep();
    i_host.wr(8'h00, 8'h03);
    settle(3);
    check("sleep", {sleep_req, low_power}, 2'h3);
    i_host.wr(8'h00, 8'h01);
    settle(3);
    check("wake", {sleep_req, low_power}, 2'h0);
    @(posedge clk);
    stream_lost <= 1'h1;
    settle(3);
    check("lost", low_power, 1'h1);
    i_host.rd(8'h00, rv);
    check("kept 0", rv, 8'h01);
    i_host.rd(8'h03, rv);
    check("kept 3", rv, 8'h07);
    @(posedge clk);
    stream_lost <= 1'h0;
  endtask
  task automatic t_power_down();
    // Sleep set first so the wipe has something to clear
    i_host.wr(8'h00, 8'h03);
    settle(3);
    check("pre pd sleep", sleep_req, 1'h1);
    @(posedge clk);
    power_down_n <= 1'h0;
    settle(8);
    check("pd power", low_power, 1'h1);
    check("pd sleep", sleep_req, 1'h0);
    i_host.wr(8'h02, 8'h80);
    @(posedge clk);
    power_down_n <= 1'h1;
    settle(6);
    check_dflt();
  endtask

  initial begin
    rst = 1'h1;
    power_down_n = 1'h1;
    stream_lost = 1'h0;
    addr_strap = 2'h0;
    strap_cfg = '0;
    failures = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    settle(6);
    t_reset();
    t_straps();
    t_regs();
    t_readback();
    t_spread();
    t_sleep();
    t_power_down();
    conclude();
  end
  // Cuts a hang short
  initial begin
    #200us;
    failures++;
    $display("ERROR watchdog expected end seen hang");
    conclude();
  end
endmodule
